// >>> rtl/trf_map.vh
// register offsets, reset values and field positions of the result formatter
`ifndef TRF_MAP_VH
`define TRF_MAP_VH
// ==================================================
// register offsets
`define TRF_OFS_INT_TEMP      8'h00
`define TRF_OFS_EXT_TEMP      8'h01
`define TRF_OFS_STATUS        8'h02
`define TRF_OFS_CONFIG        8'h03
`define TRF_OFS_RATE          8'h04
`define TRF_OFS_INT_HI        8'h05
`define TRF_OFS_INT_LO        8'h06
`define TRF_OFS_EXT_HI        8'h07
`define TRF_OFS_EXT_LO        8'h08
`define TRF_OFS_CONFIG_ALIAS  8'h09
`define TRF_OFS_RATE_ALIAS    8'h0A
`define TRF_OFS_INT_HI_ALIAS  8'h0B
`define TRF_OFS_INT_LO_ALIAS  8'h0C
`define TRF_OFS_EXT_HI_ALIAS  8'h0D
`define TRF_OFS_EXT_LO_ALIAS  8'h0E
`define TRF_OFS_EXT_FRAC      8'h10
`define TRF_OFS_INT_FRAC      8'h29
// ==================================================
// reset values
`define TRF_RST_ZERO          8'h00
`define TRF_RST_RATE          8'h06
`define TRF_RST_HI_LIMIT      8'h55
// ==================================================
// fields
`define TRF_CFG_RANGE_BIT     2
`define TRF_ST_EXT_LOW_BIT    3
`define TRF_ST_EXT_HIGH_BIT   4
`define TRF_ST_INT_LOW_BIT    5
`define TRF_ST_INT_HIGH_BIT   6
`define TRF_ST_FAULT_BIT      2
`define TRF_CODE_MAX_DEFAULT  11'h3FF
`define TRF_CODE_MAX_EXT      11'h7FF
`define TRF_CODE_ZERO         11'h000
`define TRF_EXT_OFFSET        14'h0200
`define TRF_LOW_PAD           5'h00
`endif

// >>> rtl/trf_result_regs.v
// result formatting, limit checks and register map of the temperature reader
`timescale 1ns/10ps
// Overview of operation
// - results kept as 11 bits, upper eight go to the high byte
// - lowest three result bits sit in low byte bits 7 to 5
// - low byte bits 4 to 0 always read zero
// - each stored result except a faulted external one is compared with its channel high and low limits
// - default range: unsigned eighth-degree count from zero up to 127.875
// - extended range: add 64 degree offset, zero degrees encodes as 200h
// - default range: below zero reports all-zero code
// - extended range: below minus 64 reports all-zero code
// - default range: above 127.875 saturates to 3FFh
// - extended range: above 191.875 saturates to 7FFh
// - external diode fault loads zero data and skips both the high and low limit checks
// - every register is read over the bus and all but results and status are written; the range bit and the rate also drive ext_range_out and rate_sel_out
// - unused status bits read zero; configuration and rate keep and read back all eight written bits
// - integer results at 00h and 01h, read only, reset zero
// - status at 02h clears its latched bits on read, resets zero
// - configuration shared by 03h and 09h, resets zero
// - conversion rate shared by 04h and 0Ah, resets to 06h
// - internal high limit at 05h and 0Bh, resets 55h
// - internal low limit at 06h and 0Ch, resets zero
// - external high limit integer at 07h and 0Dh, resets 55h
// - external low limit integer at 08h and 0Eh, resets zero
`include "trf_map.vh"

module trf_result_regs #(
  parameter TW = 14
) (
  input  wire          clk_in,
  input  wire          sys_rst_in,
  // conversion results: signed eighth-degree counts from the converter
  input  wire          int_valid_in,
  input  wire [TW-1:0] int_temp_in,
  input  wire          ext_valid_in,
  input  wire [TW-1:0] ext_temp_in,
  input  wire          ext_fault_in,
  // register access port from the serial slave
  input  wire          reg_wr_in,
  input  wire          reg_rd_in,
  input  wire [7:0]    reg_addr_in,
  input  wire [7:0]    reg_wdata_in,
  output reg  [7:0]    reg_rdata_out,
  output reg           reg_rvalid_out,
  output reg           ext_range_out,
  output reg  [7:0]    rate_sel_out
);

  // ==================================================
  // formatting
  // sign-extend, add the range offset, then clamp to the 11-bit code
  function [10:0] fmt_code;
    input [TW-1:0] t;
    input          ext;
    reg   [TW:0]   s;
    reg   [TW:0]   ofs;
    begin
      if (ext) begin
        ofs = {1'h0, `TRF_EXT_OFFSET};
      end else begin
        ofs = {(TW+1){1'h0}};
      end
      s = {t[TW-1], t} + ofs;
      if (s[TW]) begin
        fmt_code = `TRF_CODE_ZERO;
      end else if (!ext && (s[TW-1:0] > {3'h0, `TRF_CODE_MAX_DEFAULT})) begin
        fmt_code = `TRF_CODE_MAX_DEFAULT;
      end else if (ext && (s[TW-1:0] > {3'h0, `TRF_CODE_MAX_EXT})) begin
        fmt_code = `TRF_CODE_MAX_EXT;
      end else begin
        fmt_code = s[10:0];
      end
    end
  endfunction

  // limit byte in the same range encoding, compared on integer part
  function [10:0] lim_code;
    input [7:0] l;
    begin
      lim_code = {l, 3'h0};
    end
  endfunction

  // ==================================================
  // registers
  reg  [10:0] int_res_q;
  reg  [10:0] ext_res_q;

  reg  [7:0]  status_q;
  reg  [7:0]  config_q;
  reg  [7:0]  rate_q;

  reg  [7:0]  int_hi_q;
  reg  [7:0]  int_lo_q;
  reg  [7:0]  ext_hi_q;
  reg  [7:0]  ext_lo_q;

  reg  [7:0]  rdata_d;
  reg  [7:0]  st_set_d;

  // ==================================================
  // status bits that exist; the rest stay zero
  localparam [7:0] ST_USED = (8'h1 << `TRF_ST_INT_HIGH_BIT) |
                             (8'h1 << `TRF_ST_INT_LOW_BIT) |
                             (8'h1 << `TRF_ST_EXT_HIGH_BIT) |
                             (8'h1 << `TRF_ST_EXT_LOW_BIT) |
                             (8'h1 << `TRF_ST_FAULT_BIT);

  // ==================================================
  // formatted codes and range select
  wire        ext_mode;
  wire [10:0] int_code;
  wire [10:0] ext_code;
  wire [10:0] int_hi_code;
  wire [10:0] int_lo_code;
  wire [10:0] ext_hi_code;
  wire [10:0] ext_lo_code;
  wire        st_rd;

  assign ext_mode    = config_q[`TRF_CFG_RANGE_BIT];
  assign int_code    = fmt_code(int_temp_in, ext_mode);
  assign ext_code    = fmt_code(ext_temp_in, ext_mode);
  assign int_hi_code = lim_code(int_hi_q);
  assign int_lo_code = lim_code(int_lo_q);
  assign ext_hi_code = lim_code(ext_hi_q);
  assign ext_lo_code = lim_code(ext_lo_q);
  assign st_rd       = reg_rd_in && (reg_addr_in == `TRF_OFS_STATUS);

  // ==================================================
  // address decode, each mirror pair hits one flop
  wire        hit_config;
  wire        hit_rate;
  wire        hit_int_hi;
  wire        hit_int_lo;
  wire        hit_ext_hi;
  wire        hit_ext_lo;

  assign hit_config = (reg_addr_in == `TRF_OFS_CONFIG) ||
                      (reg_addr_in == `TRF_OFS_CONFIG_ALIAS);

  assign hit_rate   = (reg_addr_in == `TRF_OFS_RATE) ||
                      (reg_addr_in == `TRF_OFS_RATE_ALIAS);

  assign hit_int_hi = (reg_addr_in == `TRF_OFS_INT_HI) ||
                      (reg_addr_in == `TRF_OFS_INT_HI_ALIAS);

  assign hit_int_lo = (reg_addr_in == `TRF_OFS_INT_LO) ||
                      (reg_addr_in == `TRF_OFS_INT_LO_ALIAS);

  assign hit_ext_hi = (reg_addr_in == `TRF_OFS_EXT_HI) ||
                      (reg_addr_in == `TRF_OFS_EXT_HI_ALIAS);

  assign hit_ext_lo = (reg_addr_in == `TRF_OFS_EXT_LO) ||
                      (reg_addr_in == `TRF_OFS_EXT_LO_ALIAS);

  // ==================================================
  // limit checks on fresh results
  wire        int_over;
  wire        int_under;
  wire        ext_over;
  wire        ext_under;

  // high flag on reaching the limit, low flag strictly below it
  assign int_over  = (int_code >= int_hi_code);
  assign int_under = (int_code < int_lo_code);
  assign ext_over  = (ext_code >= ext_hi_code);
  assign ext_under = (ext_code < ext_lo_code);

  always @* begin
    st_set_d = `TRF_RST_ZERO;
    if (int_valid_in) begin
      st_set_d[`TRF_ST_INT_HIGH_BIT] = int_over;
      st_set_d[`TRF_ST_INT_LOW_BIT]  = int_under;
    end

    if (ext_valid_in) begin
      if (ext_fault_in) begin
        // a faulty diode gives no meaningful code, so no limit flags
        st_set_d[`TRF_ST_FAULT_BIT] = 1'h1;
      end else begin
        st_set_d[`TRF_ST_EXT_HIGH_BIT] = ext_over;
        st_set_d[`TRF_ST_EXT_LOW_BIT]  = ext_under;
      end
    end
  end

  // ==================================================
  // result storage
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_res_q <= `TRF_CODE_ZERO;
    end else if (int_valid_in) begin
      int_res_q <= int_code;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ext_res_q <= `TRF_CODE_ZERO;
    end else if (ext_valid_in) begin
      if (ext_fault_in) begin
        ext_res_q <= `TRF_CODE_ZERO;
      end else begin
        ext_res_q <= ext_code;
      end
    end
  end

  // ==================================================
  // status, a new event wins over the read that clears it
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      status_q <= `TRF_RST_ZERO;
    end else if (st_rd) begin
      status_q <= st_set_d;
    end else begin
      status_q <= status_q | st_set_d;
    end
  end

  // ==================================================
  // writable registers, mirrors share one flop
  // writes to result, status and unmapped offsets land nowhere
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      config_q <= `TRF_RST_ZERO;
    end else if (reg_wr_in) begin
      if (hit_config) begin
        config_q <= reg_wdata_in;
      end
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rate_q <= `TRF_RST_RATE;
    end else if (reg_wr_in) begin
      if (hit_rate) begin
        rate_q <= reg_wdata_in;
      end
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_hi_q <= `TRF_RST_HI_LIMIT;
    end else if (reg_wr_in) begin
      if (hit_int_hi) begin
        int_hi_q <= reg_wdata_in;
      end
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      int_lo_q <= `TRF_RST_ZERO;
    end else if (reg_wr_in) begin
      if (hit_int_lo) begin
        int_lo_q <= reg_wdata_in;
      end
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ext_hi_q <= `TRF_RST_HI_LIMIT;
    end else if (reg_wr_in) begin
      if (hit_ext_hi) begin
        ext_hi_q <= reg_wdata_in;
      end
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ext_lo_q <= `TRF_RST_ZERO;
    end else if (reg_wr_in) begin
      if (hit_ext_lo) begin
        ext_lo_q <= reg_wdata_in;
      end
    end
  end

  // ==================================================
  // read mux
  // low bytes read live, there is no shadow copy
  always @* begin
    case (reg_addr_in)
      `TRF_OFS_INT_TEMP: begin
        rdata_d = int_res_q[10:3];
      end

      `TRF_OFS_EXT_TEMP: begin
        rdata_d = ext_res_q[10:3];
      end

      `TRF_OFS_INT_FRAC: begin
        rdata_d = {int_res_q[2:0], `TRF_LOW_PAD};
      end

      `TRF_OFS_EXT_FRAC: begin
        rdata_d = {ext_res_q[2:0], `TRF_LOW_PAD};
      end

      `TRF_OFS_STATUS: begin
        rdata_d = status_q & ST_USED;
      end

      `TRF_OFS_CONFIG, `TRF_OFS_CONFIG_ALIAS: begin
        rdata_d = config_q;
      end

      `TRF_OFS_RATE, `TRF_OFS_RATE_ALIAS: begin
        rdata_d = rate_q;
      end

      `TRF_OFS_INT_HI, `TRF_OFS_INT_HI_ALIAS: begin
        rdata_d = int_hi_q;
      end

      `TRF_OFS_INT_LO, `TRF_OFS_INT_LO_ALIAS: begin
        rdata_d = int_lo_q;
      end

      `TRF_OFS_EXT_HI, `TRF_OFS_EXT_HI_ALIAS: begin
        rdata_d = ext_hi_q;
      end

      `TRF_OFS_EXT_LO, `TRF_OFS_EXT_LO_ALIAS: begin
        rdata_d = ext_lo_q;
      end

      default: begin
        rdata_d = `TRF_RST_ZERO;
      end
    endcase
  end

  // ==================================================
  // registered outputs
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= `TRF_RST_ZERO;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= `TRF_RST_ZERO;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rvalid_out <= 1'h0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // range and rate leave as flop copies for the converter
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      ext_range_out <= 1'h0;
    end else begin
      ext_range_out <= ext_mode;
    end
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rate_sel_out <= `TRF_RST_RATE;
    end else begin
      rate_sel_out <= rate_q;
    end
  end

endmodule // trf_result_regs

// >>> verif/trf_result_regs_chk.sv
// concurrent checks on the formatter register port
`timescale 1ns/10ps
module trf_result_regs_chk (
  input wire       clk_in,
  input wire       sys_rst_in,
  input wire       int_valid_in,
  input wire       ext_valid_in,
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_rvalid_out,
  input wire       ext_range_out,
  input wire [7:0] rate_sel_out
);
  // =====
  // register port
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire busy = int_valid_in || ext_valid_in;
  // a conversion beside a status read may set bits again
  sequence st_rd;
    reg_rd_in && reg_addr_in == 8'h02 && !busy;
  endsequence
  sequence cfg_wr;
    reg_wr_in && (reg_addr_in == 8'h03 || reg_addr_in == 8'h09) ##1 !reg_wr_in;
  endsequence
  sequence rate_wr;
    reg_wr_in && (reg_addr_in == 8'h04 || reg_addr_in == 8'h0A) ##1 !reg_wr_in;
  endsequence
  rd_answer_a: assert property (reg_rd_in |=> reg_rvalid_out) else $error("no answer");
  answer_cause_a: assert property (reg_rvalid_out |-> $past(reg_rd_in)) else $error("stray");
  idle_zero_a: assert property (!reg_rvalid_out |-> reg_rdata_out == 8'h00)
    else $error("idle data");
  low_pad_a: assert property (reg_rd_in && reg_addr_in inside {8'h10, 8'h29}
    |=> reg_rdata_out[4:0] == 5'h00) else $error("low bits set");
  unmapped_zero_a: assert property (reg_rd_in && reg_addr_in > 8'h29
    |=> reg_rdata_out == 8'h00) else $error("unmapped data");
  status_clear_a: assert property (st_rd ##1 !busy ##1 st_rd |=> reg_rdata_out == 8'h00)
    else $error("status kept");
  range_copy_a: assert property (cfg_wr |=> ext_range_out == $past(reg_wdata_in[2], 2))
    else $error("range stale");
  rate_copy_a: assert property (rate_wr |=> rate_sel_out == $past(reg_wdata_in, 2))
    else $error("rate stale");
endmodule // trf_result_regs_chk
bind trf_result_regs trf_result_regs_chk chk_i (.*);

// >>> verif/trf_host.sv
// register bus host model driving the formatter's access port
`timescale 1ns/10ps
module trf_host (
  input  wire       clk_in,
  output reg        wr_out,
  output reg        rd_out,
  output reg  [7:0] addr_out,
  output reg  [7:0] wdata_out,
  input  wire [7:0] rdata_in,
  input  wire       rvalid_in
);
  // =====
  // one transfer per call; on release both strobes drop, address and data show inverted values
  initial {wr_out, rd_out, addr_out, wdata_out} = 18'h00000;
  task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    @(posedge clk_in);
    {wr_out, rd_out, addr_out, wdata_out} <= {w, ~w, a, d};
    @(posedge clk_in);
    {wr_out, rd_out, addr_out, wdata_out} <= {2'h0, ~a, ~d};
    // answer stands one cycle only, so look mid-cycle
    @(negedge clk_in);
    q = rvalid_in ? rdata_in : 8'hXX;
  endtask
endmodule // trf_host

// >>> verif/trf_result_regs_tb.sv
// self-checking bench for the result formatter
`timescale 1ns/10ps
module trf_result_regs_tb;
  reg          clk_in = 1'h0;
  reg          sys_rst_in = 1'h1;
  reg          int_valid_in = 1'h0;
  reg          ext_valid_in = 1'h0;
  reg          ext_fault_in = 1'h0;
  reg  [13:0]  int_temp_in = 14'h0000;
  reg  [13:0]  ext_temp_in = 14'h0000;
  reg  [7:0]   got;
  wire         reg_wr_in, reg_rd_in, reg_rvalid_out;
  wire [7:0]   reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire         ext_range_out;
  wire [7:0]   rate_sel_out;
  integer      miscompares = 0;
  integer      check_count = 0;
  integer      i;
  // reset values of 00h..0Eh; then write address, read address, data
  localparam [119:0] rst_tab = 120'h000000000655005500000655005500;
  localparam [143:0] mir_tab = 144'h0B05A5060C3C0D0766080E990A0411090300;
  always #12.5 clk_in = ~clk_in;
  trf_host host_i (.clk_in(clk_in), .wr_out(reg_wr_in), .rd_out(reg_rd_in),
    .addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .rdata_in(reg_rdata_out),
    .rvalid_in(reg_rvalid_out));
  trf_result_regs trf_result_regs_i (.*);
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input [7:0] a, input [7:0] e);
    host_i.xfer(1'h0, a, 8'h00, got);
    check_count = check_count + 1;
    if (got !== e) begin
      miscompares = miscompares + 1;
      $display("Error %0t reg %h got %h exp %h", $time, a, got, e);
    end
  endtask
  // range and rate copies, looked at mid-cycle where they are settled
  task chk_out(input r, input [7:0] e);
    @(negedge clk_in);
    check_count = check_count + 1;
    if ({ext_range_out, rate_sel_out} !== {r, e}) begin
      miscompares = miscompares + 1;
      $display("Error %0t range %b rate %h exp %b %h", $time, ext_range_out,
        rate_sel_out, r, e);
    end
  endtask
  // =====
  // one result on both channels, then all four data bytes
  task conv(input [13:0] t, input f, input [10:0] e);
    @(posedge clk_in);
    {int_temp_in, ext_temp_in, ext_fault_in, int_valid_in, ext_valid_in} <= {t, t, f, 2'h3};
    @(posedge clk_in);
    {int_valid_in, ext_valid_in} <= 2'h0;
    chk(8'h00, e[10:3]);
    chk(8'h29, {e[2:0], 5'h00});
    chk(8'h01, f ? 8'h00 : e[10:3]);
    chk(8'h10, f ? 8'h00 : {e[2:0], 5'h00});
  endtask
  initial begin
    #100000;
    miscompares = miscompares + 1;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    for (i = 0; i < 15; i = i + 1)
      chk(i[7:0], rst_tab[119-8*i -: 8]);
    chk_out(1'h0, 8'h06);
    conv(14'h02A8, 1'h0, 11'h2A8);
    chk(8'h02, 8'h50);
    chk(8'h02, 8'h00);
    conv(14'h0064, 1'h1, 11'h064);
    chk(8'h02, 8'h04);
    conv(14'h3FF8, 1'h0, 11'h000);
    conv(14'h0400, 1'h0, 11'h3FF);
    host_i.xfer(1'h1, 8'h03, 8'h04, got);
    chk_out(1'h1, 8'h06);
    conv(14'h3DFF, 1'h0, 11'h000);
    conv(14'h0000, 1'h0, 11'h200);
    conv(14'h0600, 1'h0, 11'h7FF);
    for (i = 0; i < 6; i = i + 1) begin
      host_i.xfer(1'h1, mir_tab[143-24*i -: 8], mir_tab[127-24*i -: 8], got);
      chk(mir_tab[135-24*i -: 8], mir_tab[127-24*i -: 8]);
    end
    chk_out(1'h0, 8'h11);
    host_i.xfer(1'h1, 8'h01, 8'h5A, got);
    chk(8'h01, 8'hFF);
    chk(8'h30, 8'h00);
    finish_test;
  end
endmodule // trf_result_regs_tb
